// ### cssd_pkg.sv
package cssd_pkg;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CSSD_OP_NOP            = 5'h00,
    CSSD_OP_RELATIVE_CALL  = 5'h01,
    CSSD_OP_COMPUTED_CALL  = 5'h02,
    CSSD_OP_REPEAT_LIT     = 5'h03,
    CSSD_OP_REPEAT_REG     = 5'h04,
    CSSD_OP_SOFT_RESET     = 5'h05,
    CSSD_OP_INT_RETURN     = 5'h06,
    CSSD_OP_LIT_RETURN     = 5'h07,
    CSSD_OP_SUB_RETURN     = 5'h08,
    CSSD_OP_ROT_L_CARRY    = 5'h09,
    CSSD_OP_ROT_L_PLAIN    = 5'h0a,
    CSSD_OP_ROT_R_CARRY    = 5'h0b,
    CSSD_OP_ROT_R_PLAIN    = 5'h0c,
    CSSD_OP_SIGN_EXTEND    = 5'h0d,
    CSSD_OP_FILL_ONES      = 5'h0e,
    CSSD_OP_LEFT_SHIFT     = 5'h0f,
    CSSD_OP_LEFT_SHIFT_N   = 5'h10,
    CSSD_OP_MINUS          = 5'h11,
    CSSD_OP_MINUS_BORROW   = 5'h12,
    CSSD_OP_REV_MINUS      = 5'h13,
    CSSD_OP_REV_MINUS_BRW  = 5'h14,
    CSSD_OP_SWAP           = 5'h15,
    CSSD_OP_TBL_READ_HIGH  = 5'h16
  } cssd_op_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } cssd_flags_t;

  typedef struct packed {
    cssd_op_t    op;
    logic        byte_mode;
    logic [15:0] base;
    logic [15:0] src;
    logic [23:0] prog_word;
    logic        fast_return;
  } cssd_req_t;

  typedef struct packed {
    logic [15:0] value;
    cssd_flags_t flags;
    logic        c_we;
    logic        dc_we;
    logic        n_we;
    logic        ov_we;
    logic        z_we;
    logic        res_we;
  } cssd_alu_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [15:0] CSSD_ALL_ONES     = 16'hffff;
  localparam logic [15:0] CSSD_RESULT_RST   = 16'h0000;
  localparam logic [13:0] CSSD_REPEAT_RST   = 14'h0000;
  localparam logic [1:0]  CSSD_CYC_ONE      = 2'h1;
  localparam logic [1:0]  CSSD_CYC_TWO      = 2'h2;
  localparam logic [1:0]  CSSD_CYC_THREE    = 2'h3;
  localparam int          CSSD_LIT5_W       = 5;
  localparam int          CSSD_LIT10_W      = 10;
  localparam int          CSSD_LIT14_W      = 14;
  localparam int          CSSD_TBL_HI_LSB   = 16;

endpackage : cssd_pkg

// ### cssd_alu.sv
`timescale 1ns/1ns
module cssd_alu
(
  input  wire cssd_pkg::cssd_req_t   req,
  input  wire cssd_pkg::cssd_flags_t flags_in,
  output cssd_pkg::cssd_alu_t        res
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_zero(input logic [15:0] v, input logic bm);
    is_zero = bm ? (v[7:0] == 8'h00) : (v == 16'h0000);
  endfunction : is_zero

  function automatic logic top_bit(input logic [15:0] v, input logic bm);
    top_bit = bm ? v[7] : v[15];
  endfunction : top_bit

  logic [15:0] a;
  logic [15:0] b;
  logic        cin;
  logic [16:0] diff;
  logic [4:0]  nib;
  logic [31:0] shl;

  always_comb
  begin
    res     = '0;
    a       = req.base;
    b       = req.src;
    cin     = 1'b1;
    diff    = '0;
    nib     = '0;
    shl     = '0;
    case (req.op)
      cssd_pkg::CSSD_OP_ROT_L_CARRY:
      begin
        res.value = req.byte_mode ? {8'h00, req.src[6:0], flags_in.c}
                                  : {req.src[14:0], flags_in.c};  // RULE7
        res.flags.c = top_bit(req.src, req.byte_mode);
        res.c_we = 1'b1;
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_ROT_L_PLAIN:
      begin
        res.value = req.byte_mode ? {8'h00, req.src[6:0], req.src[7]}
                                  : {req.src[14:0], req.src[15]};  // RULE8
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_ROT_R_CARRY:
      begin
        res.value = req.byte_mode ? {8'h00, flags_in.c, req.src[7:1]}
                                  : {flags_in.c, req.src[15:1]};  // RULE9
        res.flags.c = req.src[0];
        res.c_we = 1'b1;
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_ROT_R_PLAIN:
      begin
        res.value = req.byte_mode ? {8'h00, req.src[0], req.src[7:1]}
                                  : {req.src[0], req.src[15:1]};  // RULE10
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_SIGN_EXTEND:
      begin
        // The carry takes the inverted sign, as the extension fills the high byte.
        res.value = {{8{req.src[7]}}, req.src[7:0]};  // RULE11
        res.flags.c = ~req.src[7];
        res.c_we = 1'b1;
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_FILL_ONES:
      begin
        res.value = req.byte_mode ? {8'h00, cssd_pkg::CSSD_ALL_ONES[7:0]}
                                  : cssd_pkg::CSSD_ALL_ONES;  // RULE12
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_LEFT_SHIFT:
      begin
        res.value = req.byte_mode ? {8'h00, req.src[6:0], 1'b0}
                                  : {req.src[14:0], 1'b0};  // RULE13
        res.flags.c = top_bit(req.src, req.byte_mode);
        res.flags.ov = top_bit(req.src, req.byte_mode) ^ top_bit(res.value, req.byte_mode);
        res.c_we = 1'b1;
        res.ov_we = 1'b1;
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_LEFT_SHIFT_N:
      begin
        // Only the low four count bits are used; larger counts shift by count mod 16.
        shl = {16'h0000, req.base} << req.src[3:0];  // RULE14
        res.value = shl[15:0];
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_MINUS,
      cssd_pkg::CSSD_OP_MINUS_BORROW,
      cssd_pkg::CSSD_OP_REV_MINUS,
      cssd_pkg::CSSD_OP_REV_MINUS_BRW:
      begin
        if (req.op == cssd_pkg::CSSD_OP_REV_MINUS ||
            req.op == cssd_pkg::CSSD_OP_REV_MINUS_BRW)
        begin
          a = req.src;  // RULE17
          b = req.base;
        end
        if (req.op == cssd_pkg::CSSD_OP_MINUS_BORROW ||
            req.op == cssd_pkg::CSSD_OP_REV_MINUS_BRW)
        begin
          cin = flags_in.c;  // RULE16 RULE18
        end
        if (req.byte_mode)
        begin
          a = {8'h00, a[7:0]};
          b = {8'h00, b[7:0]};
        end
        diff = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};  // RULE15
        nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        res.value = req.byte_mode ? {8'h00, diff[7:0]} : diff[15:0];
        // Nine bits, so that a byte of all ones plus the borrow does not wrap.
        res.flags.c = req.byte_mode
                    ? ({1'b0, a[7:0]} >= ({1'b0, b[7:0]} + {8'h00, ~cin}))
                    : diff[16];
        res.flags.dc = nib[4];
        res.flags.ov = (top_bit(a, req.byte_mode) ^ top_bit(b, req.byte_mode))
                     & (top_bit(a, req.byte_mode) ^ top_bit(res.value, req.byte_mode));
        res.c_we = 1'b1;
        res.dc_we = 1'b1;
        res.ov_we = 1'b1;
        res.n_we = 1'b1;
        res.z_we = 1'b1;
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_SWAP:
      begin
        res.value = req.byte_mode ? {8'h00, req.src[3:0], req.src[7:4]}
                                  : {req.src[7:0], req.src[15:8]};  // RULE19
        res.res_we = 1'b1;
      end
      cssd_pkg::CSSD_OP_TBL_READ_HIGH:
      begin
        res.value = {8'h00, req.prog_word[23:cssd_pkg::CSSD_TBL_HI_LSB]};  // RULE20
        res.res_we = 1'b1;
      end
      default:
      begin
        res.value = '0;
      end
    endcase
    res.flags.n = top_bit(res.value, req.byte_mode);  // RULE21
    res.flags.z = is_zero(res.value, req.byte_mode);  // RULE21
  end

endmodule : cssd_alu

// ### cssd_datapath.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: Relative and computed calls are one word, two cycles, flags unchanged.
// RULE2: Literal repeat runs the next instruction lit14 plus one times, one cycle.
// RULE3: Register repeat runs the next instruction register value plus one times.
// RULE4: Software reset requests a full device reset, flags left as they were.
// RULE5: Interrupt and subroutine return take three cycles, two when fast, no flags.
// RULE6: Literal return loads a 10-bit literal, three or two cycles, no flags.
// RULE7: Rotate left through carry updates C, N and Z in one cycle.
// RULE8: Plain rotate left wraps top bit to bit zero, updates N and Z.
// RULE9: Rotate right through carry updates C, N and Z in one cycle.
// RULE10: Plain rotate right wraps bit zero to top, updates N and Z.
// RULE11: Sign extend writes the extended byte and updates C, N and Z.
// RULE12: Fill ones writes all ones in one cycle, no flags.
// RULE13: Single left shift updates C, N, OV and Z in one cycle.
// RULE14: Multi-bit left shift by register or lit5 updates only N and Z.
// RULE15: Plain subtract updates C, DC, N, OV and Z in one cycle.
// RULE16: Subtract with borrow also takes the inverted carry away.
// RULE17: Reverse subtract swaps the operand order.
// RULE18: Reverse subtract with borrow swaps operands and takes inverted carry.
// RULE19: Swap exchanges nibbles in byte form and bytes in word form.
// RULE20: High table read puts program bits 23 to 16 in the low byte, two cycles.
// RULE21: N takes the result top bit and Z marks a zero result, width aware.
module cssd_datapath
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  input  wire logic                  issue,
  input  wire cssd_pkg::cssd_req_t   req,
  output cssd_pkg::cssd_flags_t      flags,
  output logic [15:0]                result,
  output logic                       result_we,
  output logic                       busy,
  output logic                       done,
  output logic                       repeat_active,
  output logic [13:0]                repeat_left,
  output logic                       soft_reset_req
);

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSSD_ST_IDLE = 2'b00,
    CSSD_ST_EXEC = 2'b01,
    CSSD_ST_LAST = 2'b11
  } cssd_state_t;

  cssd_state_t           state_q;
  cssd_state_t           state_d;
  logic [1:0]            cyc_q;
  logic [1:0]            cyc_d;
  cssd_pkg::cssd_flags_t flags_q;
  cssd_pkg::cssd_flags_t flags_d;
  logic [15:0]           result_q;
  logic [15:0]           result_d;
  logic                  result_we_q;
  logic                  result_we_d;
  logic                  done_q;
  logic                  done_d;
  logic                  rpt_q;
  logic                  rpt_d;
  logic [13:0]           rpt_cnt_q;
  logic [13:0]           rpt_cnt_d;
  logic                  rst_req_q;
  logic                  rst_req_d;
  logic                  busy_q;
  logic                  busy_d;
  logic [15:0]           pend_value_q;
  logic [15:0]           pend_value_d;
  logic                  pend_we_q;
  logic                  pend_we_d;
  cssd_pkg::cssd_alu_t   alu;

  cssd_alu u_alu
  (
    .req      (req),
    .flags_in (flags_q),
    .res      (alu)
  );

  // Cycle cost of each operation; multi-cycle ones hold their result
  // until the last cycle so the write lines up with retirement.
  function automatic logic [1:0] op_cycles(input cssd_pkg::cssd_req_t r);
    case (r.op)
      cssd_pkg::CSSD_OP_RELATIVE_CALL,
      cssd_pkg::CSSD_OP_COMPUTED_CALL,
      cssd_pkg::CSSD_OP_TBL_READ_HIGH:
        op_cycles = cssd_pkg::CSSD_CYC_TWO;
      cssd_pkg::CSSD_OP_INT_RETURN,
      cssd_pkg::CSSD_OP_LIT_RETURN,
      cssd_pkg::CSSD_OP_SUB_RETURN:
        op_cycles = r.fast_return ? cssd_pkg::CSSD_CYC_TWO : cssd_pkg::CSSD_CYC_THREE;
      default:
        op_cycles = cssd_pkg::CSSD_CYC_ONE;
    endcase
  endfunction : op_cycles

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d      = state_q;
    cyc_d        = cyc_q;
    flags_d      = flags_q;
    result_d     = result_q;
    result_we_d  = 1'b0;
    done_d       = 1'b0;
    rpt_d        = rpt_q;
    rpt_cnt_d    = rpt_cnt_q;
    rst_req_d    = 1'b0;
    pend_value_d = pend_value_q;
    pend_we_d    = pend_we_q;
    case (state_q)
      CSSD_ST_IDLE:
      begin
        if (issue)
        begin
          if (alu.c_we)
          begin
            flags_d.c = alu.flags.c;
          end
          if (alu.dc_we)
          begin
            flags_d.dc = alu.flags.dc;
          end
          if (alu.n_we)
          begin
            flags_d.n = alu.flags.n;  // RULE21
          end
          if (alu.ov_we)
          begin
            flags_d.ov = alu.flags.ov;
          end
          if (alu.z_we)
          begin
            flags_d.z = alu.flags.z;  // RULE21
          end
          // A repeated instruction consumes one pass; repeat never nests.
          if (rpt_q)
          begin
            if (rpt_cnt_q == cssd_pkg::CSSD_REPEAT_RST)
            begin
              rpt_d = 1'b0;
            end
            else
            begin
              rpt_cnt_d = rpt_cnt_q - 14'h0001;
            end
          end
          case (req.op)
            cssd_pkg::CSSD_OP_REPEAT_LIT:
            begin
              rpt_d     = 1'b1;  // RULE2
              rpt_cnt_d = req.src[cssd_pkg::CSSD_LIT14_W-1:0];
            end
            cssd_pkg::CSSD_OP_REPEAT_REG:
            begin
              rpt_d     = 1'b1;  // RULE3
              rpt_cnt_d = req.src[13:0];
            end
            cssd_pkg::CSSD_OP_SOFT_RESET:
            begin
              rst_req_d = 1'b1;  // RULE4
            end
            default:
            begin
              rst_req_d = 1'b0;
            end
          endcase
          if (op_cycles(req) == cssd_pkg::CSSD_CYC_ONE)
          begin
            result_d    = alu.value;
            result_we_d = alu.res_we;
            done_d      = 1'b1;
          end
          else
          begin
            cyc_d   = op_cycles(req) - cssd_pkg::CSSD_CYC_ONE;  // RULE1 RULE5
            state_d = (cyc_d == cssd_pkg::CSSD_CYC_ONE) ? CSSD_ST_LAST : CSSD_ST_EXEC;
            if (req.op == cssd_pkg::CSSD_OP_LIT_RETURN)
            begin
              pend_value_d = {6'h00, req.src[cssd_pkg::CSSD_LIT10_W-1:0]};  // RULE6
              pend_we_d    = 1'b1;
            end
            else
            begin
              pend_value_d = alu.value;  // RULE20
              pend_we_d    = alu.res_we;
            end
          end
        end
      end
      CSSD_ST_EXEC:
      begin
        cyc_d   = cyc_q - cssd_pkg::CSSD_CYC_ONE;
        state_d = CSSD_ST_LAST;
      end
      CSSD_ST_LAST:
      begin
        result_d    = pend_value_q;
        result_we_d = pend_we_q;
        pend_we_d   = 1'b0;
        done_d      = 1'b1;
        cyc_d       = '0;
        state_d     = CSSD_ST_IDLE;
      end
      default:
      begin
        state_d = CSSD_ST_IDLE;
      end
    endcase
    busy_d = (state_d != CSSD_ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q      <= CSSD_ST_IDLE;
      cyc_q        <= '0;
      flags_q      <= '0;
      result_q     <= cssd_pkg::CSSD_RESULT_RST;
      result_we_q  <= 1'b0;
      done_q       <= 1'b0;
      rpt_q        <= 1'b0;
      rpt_cnt_q    <= cssd_pkg::CSSD_REPEAT_RST;
      rst_req_q    <= 1'b0;
      pend_value_q <= cssd_pkg::CSSD_RESULT_RST;
      pend_we_q    <= 1'b0;
      busy_q       <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cyc_q        <= cyc_d;
      flags_q      <= flags_d;
      result_q     <= result_d;
      result_we_q  <= result_we_d;
      done_q       <= done_d;
      rpt_q        <= rpt_d;
      rpt_cnt_q    <= rpt_cnt_d;
      rst_req_q    <= rst_req_d;
      pend_value_q <= pend_value_d;
      pend_we_q    <= pend_we_d;
      busy_q       <= busy_d;
    end
  end

  assign flags          = flags_q;
  assign result         = result_q;
  assign result_we      = result_we_q;
  assign busy           = busy_q;
  assign done           = done_q;
  assign repeat_active  = rpt_q;
  assign repeat_left    = rpt_cnt_q;
  assign soft_reset_req = rst_req_q;

endmodule : cssd_datapath

// ### cssd_assertions.sv
`timescale 1ns/1ns
module cssd_assertions
(
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  issue,
  input wire cssd_pkg::cssd_req_t   req,
  input wire cssd_pkg::cssd_flags_t flags,
  input wire logic [15:0]           result,
  input wire logic                  result_we,
  input wire logic                  busy,
  input wire logic                  done,
  input wire logic                  repeat_active,
  input wire logic [13:0]           repeat_left,
  input wire logic                  soft_reset_req
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------------
  wire take    = issue && !busy;
  wire is_call = req.op inside {cssd_pkg::CSSD_OP_RELATIVE_CALL,
                                cssd_pkg::CSSD_OP_COMPUTED_CALL};
  wire is_ret  = req.op inside {cssd_pkg::CSSD_OP_INT_RETURN, cssd_pkg::CSSD_OP_LIT_RETURN,
                                cssd_pkg::CSSD_OP_SUB_RETURN};
  wire is_tbl  = req.op == cssd_pkg::CSSD_OP_TBL_READ_HIGH;
  wire one_cyc = !(is_call || is_ret || is_tbl || req.op == cssd_pkg::CSSD_OP_NOP);
  wire quiet   = is_call || is_ret || is_tbl || req.op inside {cssd_pkg::CSSD_OP_REPEAT_LIT,
                 cssd_pkg::CSSD_OP_REPEAT_REG, cssd_pkg::CSSD_OP_SOFT_RESET,
                 cssd_pkg::CSSD_OP_FILL_ONES, cssd_pkg::CSSD_OP_SWAP};

  // ------------------------------------------------------------------
  // Multi-cycle steps
  // ------------------------------------------------------------------
  sequence s_hold;
    busy && !done;
  endsequence
  sequence s_retire;
    done && !busy;
  endsequence

  a_call_timing: assert property (take && is_call |=> s_hold ##1 s_retire ##0 !result_we)
    else $error("call did not retire two cycles after it was taken");
  a_slow_return: assert property (take && is_ret && !req.fast_return |=> s_hold [*2] ##1 s_retire)
    else $error("slow return did not retire after three cycles");
  a_fast_return: assert property (take && is_ret && req.fast_return |=> s_hold ##1 s_retire)
    else $error("fast return did not retire after two cycles");
  a_table_high: assert property (take && is_tbl |=> s_hold ##1 s_retire ##0
    (result_we && result == {8'h00, $past(req.prog_word[23:16], 2)}))
    else $error("table read result or timing wrong");
  a_one_cycle: assert property (take && one_cyc |=> done && !busy)
    else $error("single cycle operation did not retire at once");
  a_quiet_flags: assert property (take && quiet |=> $stable(flags))
    else $error("flags changed by an operation that keeps them");
  a_minus_carry: assert property (take && req.op == cssd_pkg::CSSD_OP_MINUS && !req.byte_mode
    |=> flags.c == ($past(req.base) >= $past(req.src)) && result == $past(req.base) - $past(req.src))
    else $error("subtract result or carry wrong");
  a_plain_rotate: assert property (take && req.op inside {cssd_pkg::CSSD_OP_ROT_L_PLAIN,
    cssd_pkg::CSSD_OP_ROT_R_PLAIN} |=> $stable(flags.c))
    else $error("plain rotate changed carry");
  a_fill_ones: assert property (take && req.op == cssd_pkg::CSSD_OP_FILL_ONES
    |=> result_we && result == cssd_pkg::CSSD_ALL_ONES)
    else $error("fill did not write all ones");
  a_soft_reset: assert property (take && req.op == cssd_pkg::CSSD_OP_SOFT_RESET |=> soft_reset_req && done)
    else $error("soft reset request missing");
  a_repeat_load: assert property (take && req.op == cssd_pkg::CSSD_OP_REPEAT_LIT
    |=> repeat_active && repeat_left == $past(req.src[13:0]))
    else $error("repeat count not loaded");
  a_zero_flag: assert property (take && req.op == cssd_pkg::CSSD_OP_MINUS && req.base == req.src
    |=> flags.z && !flags.n && result == 16'h0000)
    else $error("zero result did not set the zero flag");
endmodule : cssd_assertions

bind cssd_datapath cssd_assertions u_cssd_chk
(
  .ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .req(req), .flags(flags),
  .result(result), .result_we(result_we), .busy(busy), .done(done),
  .repeat_active(repeat_active), .repeat_left(repeat_left), .soft_reset_req(soft_reset_req)
);

// ### cssd_datapath_tb.sv
`timescale 1ns/1ns
module cssd_datapath_tb;
  typedef struct packed {
    logic [15:0]           res;
    logic                  we;
    cssd_pkg::cssd_flags_t fl;
  } cssd_note_t;

  logic                  ref_clk;
  logic                  rst_b;
  logic                  issue;
  cssd_pkg::cssd_req_t   req;
  cssd_pkg::cssd_flags_t flags;
  logic [15:0]           result;
  logic                  result_we;
  logic                  busy;
  logic                  done;
  logic                  repeat_active;
  logic [13:0]           repeat_left;
  logic                  soft_reset_req;
  cssd_pkg::cssd_flags_t exp_fl;
  cssd_note_t            notes[$];
  cssd_note_t            seen;
  int                    error_cnt;
  int                    samples_checked;
  integer                seed;
  cssd_pkg::cssd_op_t    mops[6] = '{cssd_pkg::CSSD_OP_RELATIVE_CALL,
    cssd_pkg::CSSD_OP_COMPUTED_CALL, cssd_pkg::CSSD_OP_INT_RETURN,
    cssd_pkg::CSSD_OP_LIT_RETURN, cssd_pkg::CSSD_OP_SUB_RETURN, cssd_pkg::CSSD_OP_TBL_READ_HIGH};

  cssd_datapath uut
  (
    .ref_clk(ref_clk), .rst_b(rst_b), .issue(issue), .req(req), .flags(flags),
    .result(result), .result_we(result_we), .busy(busy), .done(done),
    .repeat_active(repeat_active), .repeat_left(repeat_left), .soft_reset_req(soft_reset_req)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // Reference model and driver
  // ------------------------------------------------------------------
  function automatic cssd_note_t model(input cssd_pkg::cssd_req_t r);
    cssd_note_t  n;
    logic [15:0] a;
    logic [15:0] b;
    logic        ci;
    logic [16:0] f;
    logic [4:0]  h;
    n.fl = exp_fl;
    n.we = 1'b1;
    n.res = 16'h0000;
    a = r.base;
    b = r.src;
    ci = 1'b1;
    if (r.op inside {cssd_pkg::CSSD_OP_REV_MINUS, cssd_pkg::CSSD_OP_REV_MINUS_BRW})
    begin
      a = r.src;
      b = r.base;
    end
    if (r.op inside {cssd_pkg::CSSD_OP_MINUS_BORROW, cssd_pkg::CSSD_OP_REV_MINUS_BRW})
      ci = exp_fl.c;
    f = {1'b0, a} + {1'b0, ~b} + {16'h0000, ci};
    h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
    case (r.op)
      cssd_pkg::CSSD_OP_ROT_L_CARRY: n.res = {a[14:0], exp_fl.c};
      cssd_pkg::CSSD_OP_ROT_L_PLAIN: n.res = {a[14:0], a[15]};
      cssd_pkg::CSSD_OP_ROT_R_CARRY: n.res = {exp_fl.c, a[15:1]};
      cssd_pkg::CSSD_OP_ROT_R_PLAIN: n.res = {a[0], a[15:1]};
      cssd_pkg::CSSD_OP_SIGN_EXTEND: n.res = {{8{a[7]}}, a[7:0]};
      cssd_pkg::CSSD_OP_FILL_ONES: n.res = cssd_pkg::CSSD_ALL_ONES;
      cssd_pkg::CSSD_OP_LEFT_SHIFT: n.res = {a[14:0], 1'b0};
      cssd_pkg::CSSD_OP_LEFT_SHIFT_N: n.res = a << b[3:0];
      cssd_pkg::CSSD_OP_SWAP: n.res = r.byte_mode ? {8'h00, a[3:0], a[7:4]} : {a[7:0], a[15:8]};
      cssd_pkg::CSSD_OP_TBL_READ_HIGH: n.res = {8'h00, r.prog_word[23:16]};
      cssd_pkg::CSSD_OP_LIT_RETURN: n.res = {6'h00, r.src[9:0]};
      cssd_pkg::CSSD_OP_MINUS, cssd_pkg::CSSD_OP_MINUS_BORROW,
      cssd_pkg::CSSD_OP_REV_MINUS, cssd_pkg::CSSD_OP_REV_MINUS_BRW:
      begin
        n.res = f[15:0];
        n.fl.c = f[16];
        n.fl.dc = h[4];
        n.fl.ov = (a[15] != b[15]) && (f[15] != a[15]);
      end
      default: n.we = 1'b0;
    endcase
    case (r.op)
      cssd_pkg::CSSD_OP_ROT_L_CARRY, cssd_pkg::CSSD_OP_LEFT_SHIFT: n.fl.c = a[15];
      cssd_pkg::CSSD_OP_ROT_R_CARRY: n.fl.c = a[0];
      cssd_pkg::CSSD_OP_SIGN_EXTEND: n.fl.c = !a[7];
      default: ;
    endcase
    if (r.op == cssd_pkg::CSSD_OP_LEFT_SHIFT)
      n.fl.ov = a[15] ^ a[14];
    if (n.we && !(r.op inside {cssd_pkg::CSSD_OP_FILL_ONES, cssd_pkg::CSSD_OP_SWAP,
                  cssd_pkg::CSSD_OP_TBL_READ_HIGH, cssd_pkg::CSSD_OP_LIT_RETURN}))
    begin
      n.fl.n = n.res[15];
      n.fl.z = (n.res == 16'h0000);
    end
    return n;
  endfunction : model

  // Issue stays high through busy cycles, so every multi-cycle op also
  // shows that a request made while busy is ignored.
  task automatic run(input cssd_pkg::cssd_req_t r);
    int         k;
    cssd_note_t n;
    n = model(r);
    exp_fl = n.fl;
    notes.push_back(n);
    req = r;
    issue = 1'b1;
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while (busy !== 1'b0 && k < 8);
    if (k == 8)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask : run

  task automatic idle;
    issue = 1'b0;
    @(negedge ref_clk);
  endtask : idle

  always @(negedge ref_clk)
  begin
    if (done === 1'b1 && notes.size() == 0)
      check(16'h0001, 16'h0000);
    else if (done === 1'b1)
    begin
      seen = notes.pop_front();
      check({15'h0000, result_we}, {15'h0000, seen.we});
      if (seen.we)
        check(result, seen.res);
      check({11'h000, flags}, {11'h000, seen.fl});
    end
  end

  initial
  begin
    cssd_pkg::cssd_req_t r;
    int                  i;
    int                  j;
    int                  v;
    seed = 32'hf00b;
    error_cnt = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    issue = 1'b0;
    req = '0;
    exp_fl = '0;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    check({6'h00, flags, done, busy, result_we, repeat_active, soft_reset_req}, 16'h0000);
    check(result, 16'h0000);
    for (i = 0; i < 260; i++)
    begin
      r = '0;
      r.op = cssd_pkg::cssd_op_t'(5'h09 + 5'(i % 13));
      r.byte_mode = (r.op == cssd_pkg::CSSD_OP_SWAP) && ((i / 13) % 2 == 1);
      r.base = 16'($random(seed));
      r.src = (i % 5 == 0) ? r.base : 16'($random(seed));
      if (r.op < cssd_pkg::CSSD_OP_LEFT_SHIFT_N || r.op == cssd_pkg::CSSD_OP_SWAP)
        r.src = r.base;
      run(r);
    end
    for (i = 0; i < 12; i++)
    begin
      r = '0;
      r.op = mops[i / 2];
      r.fast_return = i[0];
      r.src = 16'($random(seed));
      r.prog_word = 24'($random(seed));
      run(r);
    end
    for (i = 0; i < 2; i++)
    begin
      v = i ? 0 : 3;
      r = '0;
      r.op = i ? cssd_pkg::CSSD_OP_REPEAT_REG : cssd_pkg::CSSD_OP_REPEAT_LIT;
      r.src = 16'(v);
      run(r);
      check({2'b00, repeat_left}, r.src);
      for (j = 0; j <= v; j++)
      begin
        r.op = cssd_pkg::CSSD_OP_MINUS;
        r.base = 16'($random(seed));
        run(r);
        check({15'h0000, repeat_active}, {15'h0000, j < v});
      end
    end
    r = '0;
    r.op = cssd_pkg::CSSD_OP_SOFT_RESET;
    run(r);
    check({15'h0000, soft_reset_req}, 16'h0001);
    idle();
    repeat (3) @(negedge ref_clk);
    check(16'(notes.size()), 16'h0000);
    give_verdict();
  end
endmodule : cssd_datapath_tb
